// ### hw/lfc_top.sv
// led flash fault control with wishbone register access
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module lfc_top
  import lfc_pkg::*;
#(
  parameter int TICK_CYC = LFC_TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        supply_low_i,
  input  wire logic        strobe_pin_i,
  input  wire logic        mask_pin_i,
  input  wire lfc_sense_t  sense_i,
  input  wire logic        dual_lamp_i,
  output lfc_drive_t       drive_o
);
  // refuse a tick divider below one; one too large for the 16-bit counter is not refused
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be at least 1");
  end

  // pin and comparator synchronisers
  localparam int SW = $bits(lfc_sense_t) + 3;
  logic [SW-1:0] sy1_reg;
  logic [SW-1:0] sy2_reg;
  always_ff @(posedge clk_i) begin
    sy1_reg <= {supply_low_i, strobe_pin_i, mask_pin_i, sense_i};
    sy2_reg <= sy1_reg;
  end
  lfc_sense_t s;
  logic       uvlo;
  logic       strobe;
  logic       mask;
  assign {uvlo, strobe, mask, s} = sy2_reg;
  logic rst;
  assign rst = rst_i | uvlo;

  logic [7:0]  level1_reg;
  logic [7:0]  level2_reg;
  logic [5:0]  ctrl_reg;
  logic [15:0] cfg_reg;
  logic [5:0]  fault_reg;
  logic        lamp1_off_reg;
  logic        lamp2_off_reg;
  logic        ot_hold_reg;
  logic        stop_reg;
  logic        flash_d_reg;
  logic [7:0]  tmr_reg;
  logic [15:0] tick_reg;
  logic        tout_stop_reg;

  logic [1:0] mode;
  logic [1:0] mmode;
  assign mode  = ctrl_reg[1:0];
  assign mmode = ctrl_reg[3:2];

  // bus decode
  logic acc;
  logic wr;
  logic rd_fault;
  assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = acc & wb_we_i;
  assign rd_fault = acc & ~wb_we_i & (wb_adr_i == LFC_A_FAULT);

  // fault detection
  logic mode_ind;
  logic flash;
  logic ovp_ev1;
  logic ovp_ev2;
  logic sh_ev1;
  logic sh_ev2;
  logic ovp_ev;
  logic sh_ev;
  logic ntc_ev;
  logic mask_ev;
  logic tout_ev;
  logic tout_done;
  logic single1;
  logic single2;
  assign mode_ind = (mode == LFC_MODE_IND);
  assign flash    = (mode == LFC_MODE_FLASH) & ~stop_reg;
  // overvoltage counts only with low vds, suppressed cases
  assign ovp_ev1 = s.ovp & s.low_vds1 & ~mode_ind & ~cfg_reg[LFC_F_CONSTV] & ~lamp1_off_reg;
  assign ovp_ev2 = s.ovp & s.low_vds2 & ~mode_ind & ~cfg_reg[LFC_F_CONSTV] & ~lamp2_off_reg;
  assign ovp_ev  = ovp_ev1 | ovp_ev2;
  // short after startup above current floor, off in mode 01
  assign sh_ev1 = s.short_det & s.started & s.short1 & s.above1 & ~mode_ind & ~lamp1_off_reg;
  assign sh_ev2 = s.short_det & s.started & s.short2 & s.above2 & ~mode_ind & ~lamp2_off_reg;
  assign sh_ev  = sh_ev1 | sh_ev2;
  assign ntc_ev  = s.ntc & cfg_reg[LFC_F_NTC];
  assign mask_ev = flash & (mmode == LFC_MASK_TX) & mask;
  // one lamp failing alone in a dual setup
  assign single1 = dual_lamp_i & (ovp_ev1 | sh_ev1) & ~(ovp_ev2 | sh_ev2) & ~lamp2_off_reg;
  assign single2 = dual_lamp_i & (ovp_ev2 | sh_ev2) & ~(ovp_ev1 | sh_ev1) & ~lamp1_off_reg;

  // flash timeout timer
  logic pin_flash;
  logic tick;
  assign pin_flash = ctrl_reg[LFC_C_STROBE] & ctrl_reg[LFC_C_STYPE];
  assign tick      = (tick_reg == 16'(TICK_CYC - 1));
  assign tout_ev   = flash & pin_flash & strobe & (tmr_reg >= cfg_reg[15:8]) & tick;
  assign tout_done = flash & ~ctrl_reg[LFC_C_STROBE] & (tmr_reg >= cfg_reg[15:8]) & tick;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      flash_d_reg <= 1'b0;
      tmr_reg     <= 8'h00;
      tick_reg    <= 16'h0000;
    end else begin
      flash_d_reg <= flash;
      if (flash & ~flash_d_reg) begin
        tmr_reg  <= 8'h00;
        tick_reg <= 16'h0000;
      end else if (flash) begin
        tick_reg <= tick ? 16'h0000 : tick_reg + 16'h0001;
        if (tick && tmr_reg != 8'hff) tmr_reg <= tmr_reg + 8'h01;
      end
    end
  end

  // faults that zero the mode fields
  logic kill;
  assign kill = (ovp_ev & ~single1 & ~single2) | (sh_ev & ~single1 & ~single2) | ntc_ev;

  // control registers and mode field updates
  always_ff @(posedge clk_i) begin
    if (rst) begin
      level1_reg <= 8'h00;
      level2_reg <= 8'h00;
      ctrl_reg   <= 6'h00;
      cfg_reg    <= 16'h0000;
    end else begin
      if (wr && wb_adr_i == LFC_A_LEVEL1 && wb_sel_i[0]) level1_reg <= wb_dat_i[7:0];
      if (wr && wb_adr_i == LFC_A_LEVEL2 && wb_sel_i[0]) level2_reg <= wb_dat_i[7:0];
      if (wr && wb_adr_i == LFC_A_CTRL && wb_sel_i[0]) ctrl_reg <= wb_dat_i[5:0];
      if (wr && wb_adr_i == LFC_A_CFG) begin
        if (wb_sel_i[0]) cfg_reg[7:0] <= {3'h0, wb_dat_i[4:0]};
        if (wb_sel_i[1]) cfg_reg[15:8] <= wb_dat_i[15:8];
      end
      // zero both mode fields, overriding a write
      if (kill) ctrl_reg[3:0] <= 4'h0;
      // timer flash ends on its own
      else if (tout_done) ctrl_reg[1:0] <= LFC_MODE_STBY;
    end
  end

  // sticky faults, cleared on read; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst) begin
      fault_reg <= 6'h00;
    end else begin
      fault_reg <= (rd_fault ? 6'h00 : fault_reg) | {ntc_ev, tout_ev | tout_done, mask_ev,
                   s.otemp, sh_ev, ovp_ev};
    end
  end

  // per-lamp disable and converter stop state
  always_ff @(posedge clk_i) begin
    if (rst) begin
      lamp1_off_reg <= 1'b0;
      lamp2_off_reg <= 1'b0;
      stop_reg      <= 1'b0;
      ot_hold_reg   <= 1'b0;
      tout_stop_reg <= 1'b0;
    end else begin
      if (single1) lamp1_off_reg <= 1'b1;
      if (single2) lamp2_off_reg <= 1'b1;
      if (mode == LFC_MODE_STBY) begin
        lamp1_off_reg <= 1'b0;
        lamp2_off_reg <= 1'b0;
      end
      // pin flash overrun ramps down until flash mode left
      if (tout_ev) tout_stop_reg <= 1'b1;
      else if (mode != LFC_MODE_FLASH) tout_stop_reg <= 1'b0;
      // overtemp stop; latched in constant voltage mode
      if (s.otemp) ot_hold_reg <= cfg_reg[LFC_F_CONSTV];
      else if (mode == LFC_MODE_STBY) ot_hold_reg <= 1'b0;
      stop_reg <= s.otemp | ot_hold_reg | tout_stop_reg | kill;
    end
  end

  // regime selection
  logic        hi_level;
  logic        fsw;
  lfc_regime_t regime;
  assign hi_level = (level1_reg >= LFC_LEVEL_HIGH) | (level2_reg >= LFC_LEVEL_HIGH);
  // boost forces switching off
  assign fsw = cfg_reg[LFC_F_FSW] & ~cfg_reg[LFC_F_BOOST];
  always_comb begin
    if (fsw && hi_level) regime = LFC_REG_SWPWM;
    else if (cfg_reg[LFC_F_SKIP]) regime = LFC_REG_SKIP;
    else regime = LFC_REG_PWM;
  end

  // converter and source drive, registered
  logic active;
  // timeout stops at once: ramp down never overlaps a running converter
  assign active = (mode != LFC_MODE_STBY) & ~stop_reg & ~kill & ~s.otemp & ~ntc_ev &
                  ~tout_ev & ~tout_stop_reg;
  always_ff @(posedge clk_i) begin
    if (rst) begin
      drive_o <= '0;
    end else begin
      drive_o.run       <= active;
      drive_o.src1_en   <= active & ~lamp1_off_reg & ~single1;
      drive_o.src2_en   <= active & ~lamp2_off_reg & ~single2;
      drive_o.ramp_down <= tout_stop_reg | tout_ev;
      // ceiling forces skipping in any regime; pfm only before startup
      drive_o.skip_force <= s.ovp | (regime == LFC_REG_SWPWM & ~s.started);
      // 1MHz only in switching regime near max duty
      drive_o.one_mhz   <= (regime == LFC_REG_SWPWM) & s.near_max_duty & active;
      drive_o.regime    <= regime;
    end
  end

  // wishbone read data and ack, one wait state
  always_ff @(posedge clk_i) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          LFC_A_LEVEL1: wb_dat_o <= {24'h0, level1_reg};
          LFC_A_LEVEL2: wb_dat_o <= {24'h0, level2_reg};
          LFC_A_CTRL:   wb_dat_o <= {26'h0, ctrl_reg};
          LFC_A_CFG:    wb_dat_o <= {16'h0, cfg_reg};
          LFC_A_FAULT:  wb_dat_o <= {26'h0, fault_reg};
          LFC_A_STAT:   wb_dat_o <= {24'h0, 2'(regime), lamp2_off_reg, lamp1_off_reg,
                                     ot_hold_reg, tout_stop_reg, stop_reg, active};
          default:      wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : lfc_top
`default_nettype wire

// ### include/lfc_pkg.sv
// package for the led flash fault control block
package lfc_pkg;
  localparam logic [7:0] LFC_LEVEL_HIGH = 8'h40;
  localparam logic [1:0] LFC_MODE_STBY  = 2'h0;
  localparam logic [1:0] LFC_MODE_IND   = 2'h1;
  localparam logic [1:0] LFC_MODE_TORCH = 2'h2;
  localparam logic [1:0] LFC_MODE_FLASH = 2'h3;
  localparam logic [1:0] LFC_MASK_TX    = 2'h1;
  // register byte addresses
  localparam logic [7:0] LFC_A_LEVEL1 = 8'h00;
  localparam logic [7:0] LFC_A_LEVEL2 = 8'h04;
  localparam logic [7:0] LFC_A_CTRL   = 8'h08;
  localparam logic [7:0] LFC_A_CFG    = 8'h0c;
  localparam logic [7:0] LFC_A_FAULT  = 8'h10;
  localparam logic [7:0] LFC_A_STAT   = 8'h14;
  // ctrl: [1:0] mode, [3:2] mask mode, [4] strobe on, [5] strobe level type
  // cfg:  [0] freq switch, [1] skip, [2] boost, [3] const v, [4] ntc, [15:8] timeout
  localparam int LFC_C_STROBE = 4;
  localparam int LFC_C_STYPE  = 5;
  localparam int LFC_F_FSW    = 0;
  localparam int LFC_F_SKIP   = 1;
  localparam int LFC_F_BOOST  = 2;
  localparam int LFC_F_CONSTV = 3;
  localparam int LFC_F_NTC    = 4;
  // fault bit positions
  localparam int LFC_B_OVP   = 0;
  localparam int LFC_B_SHORT = 1;
  localparam int LFC_B_OTEMP = 2;
  localparam int LFC_B_MASK  = 3;
  localparam int LFC_B_TOUT  = 4;
  localparam int LFC_B_NTC   = 5;
  // timeout granularity
  localparam int LFC_TICK_NS   = 1000;
  localparam int LFC_CLK_NS    = 4;
  localparam int LFC_TICK_CYC  = LFC_TICK_NS / LFC_CLK_NS;
  typedef enum logic [1:0] {
    LFC_REG_PWM   = 2'b00,
    LFC_REG_SKIP  = 2'b01,
    LFC_REG_SWPWM = 2'b10
  } lfc_regime_t;
  typedef struct packed {
    logic ovp;
    logic short_det;
    logic otemp;
    logic ntc;
    logic low_vds1;
    logic low_vds2;
    logic short1;
    logic short2;
    logic above1;
    logic above2;
    logic near_max_duty;
    logic started;
  } lfc_sense_t;
  typedef struct packed {
    logic        run;
    logic        src1_en;
    logic        src2_en;
    logic        ramp_down;
    logic        skip_force;
    logic        one_mhz;
    lfc_regime_t regime;
  } lfc_drive_t;
endpackage : lfc_pkg

// ### sim/lfc_plant.sv
// converter and lamp model seen by the fault control block
`timescale 1ns/1ps
`default_nettype none
module lfc_plant
  import lfc_pkg::*;
(
  input  wire lfc_drive_t drive_i,
  input  wire logic [1:0] open_i,
  input  wire logic [1:0] short_i,
  input  wire logic       hot_i,
  output lfc_sense_t      sense_o
);
  logic [1:0] on_w;
  assign on_w = drive_i.run ? {drive_i.src2_en, drive_i.src1_en} : 2'h0;
  // an open lit lamp lifts the output and starves its source
  always_comb begin
    sense_o = '0;
    sense_o.ovp = |(open_i & on_w);
    {sense_o.low_vds2, sense_o.low_vds1} = open_i & on_w;
    {sense_o.short2, sense_o.short1} = short_i;
    {sense_o.above2, sense_o.above1} = on_w;
    sense_o.short_det = 1'b1;
    sense_o.otemp = hot_i;
    sense_o.started = drive_i.run; // no soft start modelled
  end
endmodule : lfc_plant
`default_nettype wire

// ### sim/lfc_sva.sv
// port checker for the flash fault control block
`timescale 1ns/1ps
`default_nettype none
module lfc_sva
  import lfc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        supply_low_i,
  input wire lfc_sense_t  sense_i,
  input wire lfc_drive_t  drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers one edge after taking, for one cycle
  ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  unmap_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i > 8'h14 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // sync delay is two edges, drive one more: margin kept in the otemp count, none in the ovp count
  otemp_stop_a: assert property (sense_i.otemp [*4] |=> !drive_o.run &&
    !drive_o.src1_en && !drive_o.src2_en) else $error("hot die still driven");
  skip_ovp_a: assert property (sense_i.ovp [*3] |=> drive_o.skip_force)
    else $error("no skip above ceiling");
  one_mhz_a: assert property (drive_o.one_mhz |-> drive_o.regime == LFC_REG_SWPWM)
    else $error("slow clock outside switching");
  ramp_stop_a: assert property (drive_o.ramp_down |-> !drive_o.run)
    else $error("ramp with converter on");
  supply_rst_a: assert property (supply_low_i [*4] |=> drive_o == '0)
    else $error("drive active on low supply");
endmodule : lfc_sva
`default_nettype wire

// ### sim/lfc_top_tb.sv
// self-checking bench for the flash fault control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module lfc_top_tb;
  import lfc_pkg::*;
  typedef struct packed {
    logic [7:0]  l1;
    logic [7:0]  l2;
    logic [3:0]  cfg;
    lfc_regime_t rg;
  } lfc_row_t;
  // levels and config bits against the regime they select
  lfc_row_t    rows [6] = '{'{8'h40, 8'h00, 4'h1, LFC_REG_SWPWM},
    '{8'h3f, 8'h7f, 4'h1, LFC_REG_SWPWM}, '{8'h3f, 8'h3f, 4'h3, LFC_REG_SKIP},
    '{8'h3f, 8'h00, 4'h1, LFC_REG_PWM}, '{8'h80, 8'h00, 4'h2, LFC_REG_SKIP},
    '{8'h80, 8'h00, 4'h5, LFC_REG_PWM}};
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic        slow = 1'b0, strb = 1'b0, mask = 1'b0, dual = 1'b0, hot = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [1:0]  open_l = 2'h0, short_l = 2'h0;
  logic [31:0] dat = 32'h0, rdat, rq;
  lfc_sense_t  sense;
  lfc_drive_t  drv;
  int          mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  lfc_top #(.TICK_CYC(2)) i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .supply_low_i(slow), .strobe_pin_i(strb),
    .mask_pin_i(mask), .sense_i(sense), .dual_lamp_i(dual), .drive_o(drv));
  lfc_plant i_plant (.drive_i(drv), .open_i(open_l), .short_i(short_l), .hot_i(hot),
    .sense_o(sense));
  // classic single cycle held until ack is seen; a hang counts as wrong
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rq = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 40) mismatches++;
  endtask : wb
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    gap(6);
    rst <= 1'b0;
    `CHK(drv, 8'h00)
    wb(0, 8'h20, 0);
    `CHK(rq, 32'h0)
    foreach (rows[i]) begin
      wb(1, LFC_A_LEVEL1, {24'h0, rows[i].l1});
      wb(1, LFC_A_LEVEL2, {24'h0, rows[i].l2});
      wb(1, LFC_A_CFG, {28'h0, rows[i].cfg});
      wb(1, LFC_A_CTRL, 32'h2);
      gap(6);
      `CHK(drv.regime, rows[i].rg)
    end
    // hot die stops, keeps mode, then restarts
    wb(1, LFC_A_CFG, 0);
    hot <= 1'b1;
    gap(6);
    `CHK(drv.run, 1'b0)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_OTEMP], 1'b1)
    wb(0, LFC_A_CTRL, 0);
    `CHK(rq[1:0], LFC_MODE_TORCH)
    hot <= 1'b0;
    gap(6);
    `CHK(drv.run, 1'b1)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_OTEMP], 1'b1)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq, 32'h0)
    // one open lamp of two: the other keeps going
    {dual, open_l} <= 3'b101;
    gap(8);
    `CHK({drv.run, drv.src1_en, drv.src2_en}, 3'b101)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_OVP], 1'b1)
    wb(1, LFC_A_CTRL, 0);
    wb(0, LFC_A_FAULT, 0);
    // low current pwm ignores open and shorted lamps
    {open_l, short_l} <= 4'hf;
    wb(1, LFC_A_CTRL, 32'h1);
    gap(8);
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq, 32'h0)
    {dual, open_l, short_l} <= 5'h01;
    wb(1, LFC_A_CTRL, 0);
    wb(1, LFC_A_CTRL, 32'h2);
    gap(8);
    `CHK(drv.run, 1'b0)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_SHORT], 1'b1)
    wb(0, LFC_A_CTRL, 0);
    `CHK(rq[3:0], 4'h0)
    // timed flash with mask raised: runs on, ends itself, timeout flagged
    {short_l, mask} <= 3'b001;
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_NTC], 1'b0)
    wb(1, LFC_A_CFG, 32'h2000);
    wb(1, LFC_A_CTRL, 32'h7);
    gap(10);
    `CHK(drv.run, 1'b1)
    gap(100);
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[4:3], 2'b11)
    wb(0, LFC_A_CTRL, 0);
    `CHK(rq[1:0], LFC_MODE_STBY)
    // pin flash held past the limit ramps down
    {mask, strb} <= 2'b01;
    wb(1, LFC_A_CTRL, 32'h33);
    gap(100);
    `CHK({drv.run, drv.ramp_down}, 2'b01)
    wb(0, LFC_A_FAULT, 0);
    `CHK(rq[LFC_B_TOUT], 1'b1)
    strb <= 1'b0;
    wb(1, LFC_A_CTRL, 0);
    // constant voltage: no restart after cooling
    wb(1, LFC_A_CFG, 32'h8);
    wb(1, LFC_A_CTRL, 32'h2);
    hot <= 1'b1;
    gap(6);
    hot <= 1'b0;
    gap(6);
    `CHK(drv.run, 1'b0)
    slow <= 1'b1;
    gap(6);
    `CHK(drv, 8'h00)
    slow <= 1'b0;
    gap(4);
    wb(0, LFC_A_CFG, 0);
    `CHK(rq, 32'h0)
    give_verdict();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #60000;
    mismatches++;
    give_verdict();
  end
endmodule : lfc_top_tb
bind lfc_top lfc_sva i_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .supply_low_i, .sense_i, .drive_o);
`default_nettype wire
